// ---- verilog/qpc_pkg.sv ----
// shared constants, types and register map of the quad pwm channel block
package qpc_pkg;

  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned CNT_W        = 10;
  localparam int unsigned CFG_W        = 12;
  localparam int unsigned CFG_PER_CH   = 3;
  localparam int unsigned ADDR_W       = 8;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] OFF_CH_INIT   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CH_TOGGLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CH_COUNT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CH_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CONFIG    = 8'h40;

  // field positions inside one channel's slice of the config word
  localparam int unsigned CFG_EN_BIT    = 0;
  localparam int unsigned CFG_CLK_BIT   = 1;
  localparam int unsigned CFG_PHASE_BIT = 2;

  // values after reset
  localparam logic [CNT_W-1:0] INIT_RST   = 10'h000;
  localparam logic [CNT_W-1:0] TOGGLE_RST = 10'h1FF;
  localparam logic [CFG_W-1:0] CONFIG_RST = 12'h000;

  // timing: the low-power peripheral rate derived from mclk
  localparam int unsigned MCLK_HZ       = 100_000_000;
  localparam int unsigned LPO_HZ        = 128_000;
  localparam int unsigned LPO_DIV       = MCLK_HZ / LPO_HZ;
  localparam int unsigned SLOW_DIV      = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [CNT_W-1:0] qpc_count_t;

  typedef struct packed {
    logic phase_inv;
    logic slow_sel;
    logic enable;
  } qpc_chan_cfg_s;

endpackage

// ---- verilog/qpc_channel.sv ----
// one pwm channel: reloading up-counter, toggle compare and phase control
`timescale 1ns/1ps
module qpc_channel (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire qpc_pkg::qpc_chan_cfg_s cfg,
  input  wire logic                  fast_tick,
  input  wire logic                  slow_tick,
  input  wire qpc_pkg::qpc_count_t   init_val,
  input  wire qpc_pkg::qpc_count_t   toggle_val,
  output qpc_pkg::qpc_count_t        count,
  output logic                       pad
);
  import qpc_pkg::*;

  localparam qpc_count_t CNT_MAX = '1;

  qpc_count_t cnt_reg;
  logic       level_reg;
  logic       pad_reg;
  logic       step;

  assign step  = cfg.enable & (cfg.slow_sel ? slow_tick : fast_tick);
  assign count = cnt_reg;
  assign pad   = pad_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg <= INIT_RST;
    end else if (!cfg.enable) begin
      cnt_reg <= init_val;
    end else if (step) begin
      if (cnt_reg == toggle_val || cnt_reg == CNT_MAX) begin
        cnt_reg <= init_val;
      end else begin
        cnt_reg <= cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      level_reg <= 1'b0;
    end else if (!cfg.enable) begin
      level_reg <= 1'b0;
    end else if (step && cnt_reg == toggle_val) begin
      level_reg <= ~level_reg;
    end
  end

  // phase change is an inversion so it takes effect without a restart
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pad_reg <= 1'b0;
    end else begin
      pad_reg <= level_reg ^ cfg.phase_inv;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_toggle_reload: assert property (step && cnt_reg == toggle_val |=>
      cnt_reg == $past(init_val) && level_reg != $past(level_reg))
    else $error("toggle match did not reload and flip");
  a_count_step: assert property (step && cnt_reg != toggle_val && cnt_reg != CNT_MAX |=>
      cnt_reg == $past(cnt_reg) + 10'h001)
    else $error("counter did not advance by one");
  a_hold_no_step: assert property (cfg.enable && !step |=> $stable(cnt_reg))
    else $error("counter moved without its selected tick");
  a_pad_phase: assert property (##1 pad_reg == ($past(level_reg) ^ $past(cfg.phase_inv)))
    else $error("pad does not follow level and phase");
  a_disabled_idle: assert property (!cfg.enable |=> cnt_reg == $past(init_val) && !level_reg)
    else $error("disabled channel not parked at initial value");

  c_toggle_seen: cover property (step && cnt_reg == toggle_val);
endmodule

// ---- verilog/qpc_top.sv ----
// quad pwm channels with an axi4-lite register slave and pad drivers
//
// Contract
// - four independent channels, each own counter and compares
// - per-channel 10-bit initial value, read/write
// - per-channel 10-bit toggle value, read/write
// - per-channel counter readable, writes ignored
// - one shared 12-bit config word with enables
// - config selects each channel's counting clock
// - config changes each channel's output phase
// - outputs reach four fixed pads only
// - low-power clock requested only while enabled
`timescale 1ns/1ps
module qpc_top #(
  parameter int unsigned LPO_DIVIDE = qpc_pkg::LPO_DIV
) (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [qpc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [qpc_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                 arprot,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            lpo_clk_req,
  output logic                            wave_pad_a,
  output logic                            wave_pad_b,
  output logic                            wave_pad_dual_bonded,
  output logic                            wave_pad_d
);
  import qpc_pkg::*;

  if (LPO_DIVIDE < 2 || LPO_DIVIDE > 65536) begin : g_bad_divide
    $error("LPO_DIVIDE out of range");
  end

  qpc_count_t       init_reg   [NUM_CH];
  qpc_count_t       toggle_reg [NUM_CH];
  qpc_count_t       count_w    [NUM_CH];
  logic [CFG_W-1:0] cfg_reg;
  qpc_chan_cfg_s    ch_cfg     [NUM_CH];
  logic [NUM_CH-1:0] pad_w;
  logic [NUM_CH-1:0] en_w;

  // ---------------- axi4-lite write side
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              commit;
  logic              wr_is_ch;
  logic [1:0]        wr_ch;
  logic [15:0]       wr_merge_init;
  logic [15:0]       wr_merge_tog;
  logic [15:0]       wr_merge_cfg;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
  endfunction

  assign commit   = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_is_ch = aw_addr_reg[7:6] == 2'b00;
  assign wr_ch    = aw_addr_reg[5:4];
  assign wr_merge_init = merge16({6'h00, init_reg[wr_ch]}, w_data_reg, w_strb_reg);
  assign wr_merge_tog  = merge16({6'h00, toggle_reg[wr_ch]}, w_data_reg, w_strb_reg);
  assign wr_merge_cfg  = merge16({4'h0, cfg_reg}, w_data_reg, w_strb_reg);

  // address and data are captured independently, in either order
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      aw_addr_reg <= '0;
    end else if (awvalid && awready_reg) begin
      aw_full_reg <= 1'b1;
      awready_reg <= 1'b0;
      aw_addr_reg <= awaddr;
    end else if (bvalid_reg && bready) begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b1;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid && wready_reg) begin
      w_full_reg <= 1'b1;
      wready_reg <= 1'b0;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (bvalid_reg && bready) begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (commit) begin
      bvalid_reg <= 1'b1;
      // counter word is mapped but read-only, so a write there is accepted and dropped
      if ((wr_is_ch && aw_addr_reg[3:2] != 2'b11) || aw_addr_reg[7:2] == OFF_CONFIG[7:2]) begin
        bresp_reg <= RESP_OKAY;
      end else begin
        bresp_reg <= RESP_SLVERR;
      end
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ---------------- register storage
  for (genvar n = 0; n < NUM_CH; n++) begin : g_regs
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        init_reg[n]   <= INIT_RST;
        toggle_reg[n] <= TOGGLE_RST;
      end else if (commit && wr_is_ch && wr_ch == 2'(n)) begin
        if (aw_addr_reg[3:2] == OFF_CH_INIT[3:2]) begin
          init_reg[n] <= wr_merge_init[CNT_W-1:0];
        end
        if (aw_addr_reg[3:2] == OFF_CH_TOGGLE[3:2]) begin
          toggle_reg[n] <= wr_merge_tog[CNT_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_reg <= CONFIG_RST;
    end else if (commit && aw_addr_reg[7:2] == OFF_CONFIG[7:2]) begin
      cfg_reg <= wr_merge_cfg[CFG_W-1:0];
    end
  end

  // ---------------- axi4-lite read side
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;

  always_comb begin
    rd_mux  = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (araddr[7:6] == 2'b00) begin
      unique case (araddr[3:2])
        OFF_CH_INIT[3:2]:   rd_mux = {22'h00_0000, init_reg[araddr[5:4]]};
        OFF_CH_TOGGLE[3:2]: rd_mux = {22'h00_0000, toggle_reg[araddr[5:4]]};
        OFF_CH_COUNT[3:2]:  rd_mux = {22'h00_0000, count_w[araddr[5:4]]};
        default:            rd_resp = RESP_SLVERR;
      endcase
    end else if (araddr[7:2] == OFF_CONFIG[7:2]) begin
      rd_mux = {20'h0_0000, cfg_reg};
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_resp;
    end else if (rvalid_reg && rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ---------------- low-power peripheral clock, modelled as an mclk enable
  logic        clk_req_reg;
  logic [15:0] lpo_cnt_reg;
  logic        tick_reg;
  logic [2:0]  slow_cnt_reg;
  logic        slow_tick_reg;

  for (genvar n = 0; n < NUM_CH; n++) begin : g_cfg
    assign ch_cfg[n].enable    = cfg_reg[n*CFG_PER_CH + CFG_EN_BIT];
    assign ch_cfg[n].slow_sel  = cfg_reg[n*CFG_PER_CH + CFG_CLK_BIT];
    assign ch_cfg[n].phase_inv = cfg_reg[n*CFG_PER_CH + CFG_PHASE_BIT];
    assign en_w[n]             = ch_cfg[n].enable;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clk_req_reg <= 1'b0;
    end else begin
      clk_req_reg <= |en_w;
    end
  end

  // divider only runs while the clock is requested, mirroring a gated oscillator
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lpo_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end else if (!clk_req_reg) begin
      lpo_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end else if (lpo_cnt_reg == 16'(LPO_DIVIDE - 1)) begin
      lpo_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b1;
    end else begin
      lpo_cnt_reg <= lpo_cnt_reg + 16'h0001;
      tick_reg    <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      slow_cnt_reg  <= 3'h0;
      slow_tick_reg <= 1'b0;
    end else if (!clk_req_reg) begin
      slow_cnt_reg  <= 3'h0;
      slow_tick_reg <= 1'b0;
    end else begin
      slow_tick_reg <= tick_reg && slow_cnt_reg == 3'(SLOW_DIV - 1);
      if (tick_reg) begin
        slow_cnt_reg <= slow_cnt_reg + 3'h1;
      end
    end
  end

  // ---------------- channels and pads
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    qpc_channel u_ch (
      .mclk       (mclk),
      .reset      (reset),
      .cfg        (ch_cfg[n]),
      .fast_tick  (tick_reg),
      .slow_tick  (slow_tick_reg),
      .init_val   (init_reg[n]),
      .toggle_val (toggle_reg[n]),
      .count      (count_w[n]),
      .pad        (pad_w[n])
    );
  end

  // fixed routing, channel n to pad n; the dual-bonded pad drives whichever pin is used
  assign wave_pad_a           = pad_w[0];
  assign wave_pad_b           = pad_w[1];
  assign wave_pad_dual_bonded = pad_w[2];
  assign wave_pad_d           = pad_w[3];

  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rdata       = rdata_reg;
  assign rresp       = rresp_reg;
  assign lpo_clk_req = clk_req_reg;

  // ---------------- checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_req_follows_en: assert property (##1 clk_req_reg == |$past(en_w))
    else $error("clock request does not follow channel enables");
  // request may drop at the very edge that launches a tick, so look one cycle back
  a_tick_needs_req: assert property (tick_reg |-> $past(clk_req_reg)
      && $past(lpo_cnt_reg) == 16'(LPO_DIVIDE - 1) ##1 !tick_reg)
    else $error("tick without request or off the divider count");
  a_write_answer: assert property (commit |=> bvalid_reg && !commit)
    else $error("complete write not answered next cycle");
  a_cfg_readback: assert property (arvalid && arready_reg && araddr[7:2] == OFF_CONFIG[7:2]
      |=> rvalid_reg && rdata_reg == {20'h0_0000, $past(cfg_reg)})
    else $error("config readback mismatch");
  a_count_ro: assert property (commit && wr_is_ch && aw_addr_reg[3:2] == OFF_CH_COUNT[3:2]
      |=> $stable(init_reg[wr_ch]) && $stable(toggle_reg[wr_ch]))
    else $error("counter write disturbed another register");
  a_rdata_hold: assert property (rvalid_reg && !rready |=> rvalid_reg && $stable(rdata_reg))
    else $error("read data changed while waiting");
  a_init_store: assert property (commit && wr_is_ch && aw_addr_reg[3:2] == 2'b00
      && w_strb_reg[1:0] == 2'b11 |=> init_reg[$past(wr_ch)] == $past(w_data_reg[9:0]))
    else $error("initial value write not stored");
  a_toggle_store: assert property (commit && wr_is_ch && aw_addr_reg[3:2] == 2'b01
      && w_strb_reg[1:0] == 2'b11 |=> toggle_reg[$past(wr_ch)] == $past(w_data_reg[9:0]))
    else $error("toggle value write not stored");

  c_cfg_write: cover property (commit && aw_addr_reg[7:2] == OFF_CONFIG[7:2]);
  c_slow_tick: cover property (slow_tick_reg);
  c_count_read: cover property (arvalid && arready_reg && araddr[3:2] == 2'b10);
endmodule

// ---- testbench/quad_pwm_channels_tb.sv ----
// self-checking bench for the quad pwm channel block over axi4-lite
`timescale 1ns/1ps
module quad_pwm_channels_tb;
  import qpc_pkg::*;

  localparam int unsigned DIV = 4;

  logic                mclk;
  logic                reset;
  logic                awvalid;
  logic                awready;
  logic [ADDR_W-1:0]   awaddr;
  logic                wvalid;
  logic                wready;
  logic [31:0]         wdata;
  logic [3:0]          wstrb;
  logic                bvalid;
  logic                bready;
  logic [1:0]          bresp;
  logic                arvalid;
  logic                arready;
  logic [ADDR_W-1:0]   araddr;
  logic                rvalid;
  logic                rready;
  logic [31:0]         rdata;
  logic [1:0]          rresp;
  logic                lpo_clk_req;
  logic [3:0]          pads;
  int                  error_cnt;
  int                  n_checks;
  int                  cyc;

  // short tick divider keeps each pwm period to between 24 and 128 mclk cycles
  qpc_top #(.LPO_DIVIDE(DIV)) dut (
    .mclk                 (mclk),
    .reset                (reset),
    .awvalid              (awvalid),
    .awready              (awready),
    .awaddr               (awaddr),
    .awprot               (3'h0),
    .wvalid               (wvalid),
    .wready               (wready),
    .wdata                (wdata),
    .wstrb                (wstrb),
    .bvalid               (bvalid),
    .bready               (bready),
    .bresp                (bresp),
    .arvalid              (arvalid),
    .arready              (arready),
    .araddr               (araddr),
    .arprot               (3'h0),
    .rvalid               (rvalid),
    .rready               (rready),
    .rdata                (rdata),
    .rresp                (rresp),
    .lpo_clk_req          (lpo_clk_req),
    .wave_pad_a           (pads[0]),
    .wave_pad_b           (pads[1]),
    .wave_pad_dual_bonded (pads[2]),
    .wave_pad_d           (pads[3])
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ceiling is some tens of times the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("BAD t=%0t timeout", $time);
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [ADDR_W-1:0] ra(input int ch, input logic [ADDR_W-1:0] off);
    return off + ADDR_W'(ch) * OFF_CH_STRIDE;
  endfunction

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge mclk);
    check(32'(bresp), 32'(er));
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  // compares only the bits in mask, so a running counter can be bracketed
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] mask,
                    input logic [1:0] er);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge mclk); while (!(arvalid === 1'b1 && arready === 1'b1));
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge mclk);
    check(32'(rresp), 32'(er));
    check(rdata & mask, exp);
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
  endtask

  // cycles between two successive level changes of one pad
  task automatic period(input int ch, input int exp);
    int   n;
    logic last;
    @(posedge mclk);
    last = pads[ch];
    while (pads[ch] === last) @(posedge mclk);
    last = pads[ch];
    n = 0;
    while (pads[ch] === last) begin
      @(posedge mclk);
      n++;
    end
    check(32'(n), 32'(exp));
  endtask

  logic [CNT_W-1:0] init_v [4] = '{10'h3FD, 10'h000, 10'h005, 10'h3FE};
  logic [CNT_W-1:0] tog_v  [4] = '{10'h3FF, 10'h001, 10'h008, 10'h005};
  logic [ADDR_W-1:0] holes [3] = '{8'h0C, 8'h44, 8'hFC};
  logic              pad_moved;

  initial begin
    reset = 1'b1;
    awvalid = 1'b0;
    awaddr = '0;
    wvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = '0;
    rready = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    do_reset();
    check(32'({lpo_clk_req, pads}), 32'h0000_0000);
    for (int ch = 0; ch < 4; ch++) begin
      rd(ra(ch, OFF_CH_INIT), 32'(INIT_RST), 32'hFFFF_FFFF, RESP_OKAY);
      rd(ra(ch, OFF_CH_TOGGLE), 32'(TOGGLE_RST), 32'hFFFF_FFFF, RESP_OKAY);
      rd(ra(ch, OFF_CH_COUNT), 32'(INIT_RST), 32'hFFFF_FFFF, RESP_OKAY);
    end
    rd(OFF_CONFIG, 32'(CONFIG_RST), 32'hFFFF_FFFF, RESP_OKAY);
    // junk above bit 9 must be dropped by the 10-bit fields
    for (int ch = 0; ch < 4; ch++) begin
      wr(ra(ch, OFF_CH_INIT), 32'h5A5A_FC00 | 32'(init_v[ch]), RESP_OKAY);
      wr(ra(ch, OFF_CH_TOGGLE), 32'hA5A5_FC00 | 32'(tog_v[ch]), RESP_OKAY);
      wr(ra(ch, OFF_CH_COUNT), 32'h0000_0123, RESP_OKAY);
    end
    for (int ch = 0; ch < 4; ch++) begin
      rd(ra(ch, OFF_CH_INIT), 32'(init_v[ch]), 32'hFFFF_FFFF, RESP_OKAY);
      rd(ra(ch, OFF_CH_TOGGLE), 32'(tog_v[ch]), 32'hFFFF_FFFF, RESP_OKAY);
      rd(ra(ch, OFF_CH_COUNT), 32'(init_v[ch]), 32'hFFFF_FFFF, RESP_OKAY);
    end
    foreach (holes[i]) begin
      wr(holes[i], 32'h0000_0FFF, RESP_SLVERR);
      rd(holes[i], 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
    end
    // phase inversion alone: pads rise while the clock stays unrequested
    wr(OFF_CONFIG, 32'hFFFF_F924, RESP_OKAY);
    rd(OFF_CONFIG, 32'h0000_0924, 32'hFFFF_FFFF, RESP_OKAY);
    repeat (3) @(posedge mclk);
    check(32'({lpo_clk_req, pads}), 32'h0000_000F);
    // ch0 fast top boundary, ch1 slow, ch2 fast inverted, ch3 wraps below toggle
    wr(OFF_CONFIG, 32'h0000_0359, RESP_OKAY);
    repeat (3) @(posedge mclk);
    check(32'(lpo_clk_req), 32'h0000_0001);
    period(0, 3 * DIV);
    period(1, 2 * DIV * 8);
    period(2, 4 * DIV);
    rd(ra(0, OFF_CH_COUNT), 32'h0000_03FC, 32'h0000_03FC, RESP_OKAY);
    rd(ra(3, OFF_CH_COUNT), 32'h0000_03FE, 32'h0000_03FE, RESP_OKAY);
    pad_moved = 1'b0;
    repeat (200) begin
      @(posedge mclk);
      if (pads[3] !== 1'b0) pad_moved = 1'b1;
    end
    check(32'(pad_moved), 32'h0000_0000);
    wr(OFF_CONFIG, 32'h0000_0000, RESP_OKAY);
    repeat (3) @(posedge mclk);
    check(32'({lpo_clk_req, pads}), 32'h0000_0000);
    rd(ra(0, OFF_CH_COUNT), 32'(init_v[0]), 32'hFFFF_FFFF, RESP_OKAY);
    // byte lanes one at a time: the other lane must keep its old bits
    wstrb <= 4'h1;
    wr(ra(1, OFF_CH_INIT), 32'h0000_03AA, RESP_OKAY);
    rd(ra(1, OFF_CH_INIT), 32'h0000_00AA, 32'hFFFF_FFFF, RESP_OKAY);
    wstrb <= 4'h2;
    wr(ra(1, OFF_CH_INIT), 32'h0000_0355, RESP_OKAY);
    rd(ra(1, OFF_CH_INIT), 32'h0000_03AA, 32'hFFFF_FFFF, RESP_OKAY);
    wstrb <= 4'hF;
    // second reset in mid-run restores the defaults
    wr(OFF_CONFIG, 32'h0000_0001, RESP_OKAY);
    do_reset();
    check(32'({lpo_clk_req, pads}), 32'h0000_0000);
    rd(OFF_CONFIG, 32'(CONFIG_RST), 32'hFFFF_FFFF, RESP_OKAY);
    rd(ra(2, OFF_CH_TOGGLE), 32'(TOGGLE_RST), 32'hFFFF_FFFF, RESP_OKAY);
    summarize();
  end
endmodule
